/* File: fault_supervisor.sv */
/*
 * Overcurrent and over-temperature fault supervision of a buck converter.
 * Assumes decoded PMBus register accesses, analog comparator and ADC results
 * already synchronous to core_clk, and one cycle_start pulse per switching cycle.
 */
`timescale 1ns/1ns
module fault_supervisor #(
    parameter int AVG_SHIFT = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Decoded register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_cmd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Power stage timing and sense
    input wire logic cycle_start,
    input wire logic ls_mid,
    input wire logic [15:0] cur_sample,
    input wire logic hs_on,
    input wire logic high_side_peak_overcurrent,
    input wire logic ss_period_tick,
    input wire logic ss_done,
    // Temperature sense
    input wire logic die_temp_valid,
    input wire logic signed [15:0] die_temp,
    input wire logic ext_temp_valid,
    input wire logic signed [15:0] ext_temp,
    input wire logic sensor_pin_grounded,
    // Control outputs
    output logic hs_terminate,
    output logic convert_enable,
    output logic softstart_req,
    output logic softstart_detect_sel,
    output logic alert_n
);
    typedef enum logic [1:0] {
        OC_RUN = 2'b00,
        OC_HICCUP = 2'b01,
        OC_RESTART = 2'b10,
        OC_LATCHED = 2'b11
    } oc_state_t;

    logic [15:0] cal_offset_ff, oc_fault_thr_ff, oc_warn_thr_ff;
    logic [15:0] ot_fault_thr_ff, ot_warn_thr_ff, misc_opts_ff;
    logic [1:0] oc_resp_ff, ot_resp_ff;
    logic [7:0] alert_mask_ff, stat_iout_ff, stat_temp_ff, stat_mfr_ff;
    logic signed [15:0] iout_telem_ff, ext_read_ff, cal_sample, avg_cur;
    logic [1:0] oc_cnt_ff;
    logic [2:0] hic_cnt_ff;
    logic oc_seen_ff, oc_fault_evt, tsd_ff, ext_halt_ff, ext_latch_ff;
    logic ls_oc, ssdd, ext_fault_now, ext_warn_now, ext_live;
    oc_state_t state_ff, nxt_state;

    assign ssdd = misc_opts_ff[fault_pkg::MISC_SSDD_BIT];
    assign softstart_detect_sel = ~ssdd;

    // Register writes; status registers are handled with their setters
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cal_offset_ff <= fault_pkg::RST_CAL_OFFSET;
            oc_fault_thr_ff <= fault_pkg::RST_OC_FAULT_THR;
            oc_warn_thr_ff <= fault_pkg::RST_OC_WARN_THR;
            ot_fault_thr_ff <= fault_pkg::RST_OT_FAULT_THR;
            ot_warn_thr_ff <= fault_pkg::RST_OT_WARN_THR;
            misc_opts_ff <= fault_pkg::RST_MISC_OPTS;
            oc_resp_ff <= fault_pkg::RST_RESPONSE;
            ot_resp_ff <= fault_pkg::RST_RESPONSE;
            alert_mask_ff <= fault_pkg::RST_ALERT_MASK;
        end else if (reg_wr) begin
            case (reg_cmd)
                fault_pkg::CMD_CAL_OFFSET: cal_offset_ff <= reg_wdata;
                fault_pkg::CMD_OC_FAULT_THR: oc_fault_thr_ff <= reg_wdata;
                fault_pkg::CMD_OC_WARN_THR: oc_warn_thr_ff <= reg_wdata;
                fault_pkg::CMD_OT_FAULT_THR: ot_fault_thr_ff <= reg_wdata;
                fault_pkg::CMD_OT_WARN_THR: ot_warn_thr_ff <= reg_wdata;
                fault_pkg::CMD_MISC_OPTS: misc_opts_ff <= reg_wdata;
                fault_pkg::CMD_OC_RESPONSE: oc_resp_ff <= reg_wdata[1:0];
                fault_pkg::CMD_OT_RESPONSE: ot_resp_ff <= reg_wdata[1:0];
                fault_pkg::CMD_ALERT_MASK: alert_mask_ff <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Calibration shifts both the telemetry path and the fault comparison
    assign cal_sample = 16'(signed'(cur_sample) + signed'(cal_offset_ff));
    assign ls_oc = ls_mid && (cal_sample > signed'(oc_fault_thr_ff));

    current_averager #(.SHIFT(AVG_SHIFT)) u_avg (
        .core_clk(core_clk),
        .rstn(rstn),
        .sample_valid(ls_mid),
        .sample(cal_sample),
        .average(avg_cur)
    );

    // Telemetry follows the average one cycle later, two cycles after each sample
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            iout_telem_ff <= '0;
        end else begin
            iout_telem_ff <= avg_cur;
        end
    end

    // Peak limit cuts the high-side pulse combinationally, whatever the state
    assign hs_terminate = hs_on && high_side_peak_overcurrent;

    // Per-cycle event latch and consecutive counter
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            oc_seen_ff <= 1'b0;
            oc_cnt_ff <= '0;
        end else if (cycle_start) begin
            oc_seen_ff <= ls_oc || hs_terminate;
            if (oc_seen_ff && oc_cnt_ff != fault_pkg::OC_EVENTS_TO_FAULT) begin
                oc_cnt_ff <= oc_cnt_ff + 2'h1;
            end else if (!oc_seen_ff) begin
                oc_cnt_ff <= '0;
            end
        end else if (ls_oc || hs_terminate) begin
            oc_seen_ff <= 1'b1;
        end
    end

    // Fault declared on the cycle boundary that completes the third event
    assign oc_fault_evt = cycle_start && oc_seen_ff
        && oc_cnt_ff == fault_pkg::OC_EVENTS_TO_FAULT - 2'h1;

    // Response state machine for overcurrent
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            OC_RUN: begin
                if (oc_fault_evt && oc_resp_ff == fault_pkg::RESP_LATCH) begin
                    nxt_state = OC_LATCHED;
                end else if (oc_fault_evt && oc_resp_ff == fault_pkg::RESP_RESTART) begin
                    nxt_state = OC_HICCUP;
                end
            end
            OC_HICCUP: begin
                if (ss_period_tick && hic_cnt_ff == fault_pkg::HICCUP_SS_PERIODS - 3'h1) begin
                    nxt_state = OC_RESTART;
                end
            end
            OC_RESTART: begin
                if (oc_fault_evt && oc_resp_ff != fault_pkg::RESP_IGNORE) begin
                    nxt_state = OC_HICCUP;
                end else if (ss_done) begin
                    nxt_state = OC_RUN;
                end
            end
            OC_LATCHED: nxt_state = OC_LATCHED;
            default: nxt_state = OC_RUN;
        endcase
    end

    // State and hiccup period count
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_ff <= OC_RUN;
            hic_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff != OC_HICCUP) begin
                hic_cnt_ff <= '0;
            end else if (ss_period_tick) begin
                hic_cnt_ff <= hic_cnt_ff + 3'h1;
            end
        end
    end

    // Restart request is one pulse as the hiccup wait expires
    assign softstart_req = (state_ff == OC_HICCUP) && (nxt_state == OC_RESTART);

    // Internal shutdown with hysteresis, independent of the sensor pin
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tsd_ff <= 1'b0;
        end else if (die_temp_valid) begin
            if (die_temp > fault_pkg::TSD_DEG) begin
                tsd_ff <= 1'b1;
            end else if (die_temp <= fault_pkg::TSD_DEG - fault_pkg::TSD_HYST_DEG) begin
                tsd_ff <= 1'b0;
            end
        end
    end

    // External reading: fixed in soft-start mode, floor when pin grounded
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ext_read_ff <= fault_pkg::EXT_SS_MODE_DEG;
        end else if (!ssdd) begin
            ext_read_ff <= fault_pkg::EXT_SS_MODE_DEG;
        end else if (sensor_pin_grounded) begin
            ext_read_ff <= fault_pkg::EXT_FLOOR_DEG;
        end else if (ext_temp_valid) begin
            ext_read_ff <= ext_temp;
        end
    end

    // Only a live sensor may trip; soft-start mode and a grounded pin never do
    assign ext_live = ssdd && !sensor_pin_grounded && ext_temp_valid;
    assign ext_fault_now = ext_live && (ext_temp > signed'(ot_fault_thr_ff));
    assign ext_warn_now = ext_live && (ext_temp > signed'(ot_warn_thr_ff));

    // External fault halt: restart waits for cooling, latch holds till reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ext_halt_ff <= 1'b0;
            ext_latch_ff <= 1'b0;
        end else if (ext_fault_now && ot_resp_ff == fault_pkg::RESP_LATCH) begin
            ext_latch_ff <= 1'b1;
        end else if (ext_fault_now && ot_resp_ff == fault_pkg::RESP_RESTART) begin
            ext_halt_ff <= 1'b1;
        end else if (ext_halt_ff && ext_live
                     && ext_temp <= signed'(ot_fault_thr_ff) - fault_pkg::EXT_RECOVER_DEG) begin
            ext_halt_ff <= 1'b0;
        end
    end

    assign convert_enable = (state_ff == OC_RUN || state_ff == OC_RESTART)
        && !tsd_ff && !ext_halt_ff && !ext_latch_ff;

    // Sticky status; a set in the same cycle as a write-one clear wins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            stat_iout_ff <= '0;
            stat_temp_ff <= '0;
            stat_mfr_ff <= '0;
        end else begin
            if (reg_wr && reg_cmd == fault_pkg::CMD_STATUS_IOUT) begin
                stat_iout_ff <= stat_iout_ff & ~reg_wdata[7:0];
            end
            if (reg_wr && reg_cmd == fault_pkg::CMD_STATUS_TEMP) begin
                stat_temp_ff <= stat_temp_ff & ~reg_wdata[7:0];
            end
            if (reg_wr && reg_cmd == fault_pkg::CMD_STATUS_MFR) begin
                stat_mfr_ff <= stat_mfr_ff & ~reg_wdata[7:0];
            end
            if (oc_fault_evt) begin
                stat_iout_ff[fault_pkg::STAT_OC_FAULT_BIT] <= 1'b1;
            end
            if (ls_mid && cal_sample > signed'(oc_warn_thr_ff)) begin
                stat_iout_ff[fault_pkg::STAT_OC_WARN_BIT] <= 1'b1;
            end
            if (ext_fault_now) begin
                stat_temp_ff[fault_pkg::STAT_OT_FAULT_BIT] <= 1'b1;
            end
            if (ext_warn_now) begin
                stat_temp_ff[fault_pkg::STAT_OT_WARN_BIT] <= 1'b1;
            end
            if (tsd_ff) begin
                stat_mfr_ff[fault_pkg::MFR_INTERNAL_OVERTEMP_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // Alert is low while any unmasked status register holds a flag
    assign alert_n = !((|stat_iout_ff && !alert_mask_ff[fault_pkg::MASK_IOUT_BIT])
        || (|stat_temp_ff && !alert_mask_ff[fault_pkg::MASK_TEMP_BIT])
        || (|stat_mfr_ff && !alert_mask_ff[fault_pkg::MASK_MFR_BIT]));

    // Read data registered; unknown codes read zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_cmd)
                    fault_pkg::CMD_CAL_OFFSET: reg_rdata <= cal_offset_ff;
                    fault_pkg::CMD_OC_FAULT_THR: reg_rdata <= oc_fault_thr_ff;
                    fault_pkg::CMD_OC_WARN_THR: reg_rdata <= oc_warn_thr_ff;
                    fault_pkg::CMD_OT_FAULT_THR: reg_rdata <= ot_fault_thr_ff;
                    fault_pkg::CMD_OT_WARN_THR: reg_rdata <= ot_warn_thr_ff;
                    fault_pkg::CMD_MISC_OPTS: reg_rdata <= misc_opts_ff;
                    fault_pkg::CMD_OC_RESPONSE: reg_rdata <= {14'h0000, oc_resp_ff};
                    fault_pkg::CMD_OT_RESPONSE: reg_rdata <= {14'h0000, ot_resp_ff};
                    fault_pkg::CMD_ALERT_MASK: reg_rdata <= {8'h00, alert_mask_ff};
                    fault_pkg::CMD_STATUS_IOUT: reg_rdata <= {8'h00, stat_iout_ff};
                    fault_pkg::CMD_STATUS_TEMP: reg_rdata <= {8'h00, stat_temp_ff};
                    fault_pkg::CMD_STATUS_MFR: reg_rdata <= {8'h00, stat_mfr_ff};
                    fault_pkg::CMD_IOUT_TELEM: reg_rdata <= iout_telem_ff;
                    fault_pkg::CMD_EXT_TEMP: reg_rdata <= ext_read_ff;
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Checks on the response behaviour
    property p_hs_cut;
        @(posedge core_clk) disable iff (!rstn)
        (hs_on && high_side_peak_overcurrent) |-> hs_terminate ##1 oc_seen_ff;
    endproperty
    a_hs_cut: assert property (p_hs_cut) else $error("peak not cut");

    property p_cnt_clear;
        @(posedge core_clk) disable iff (!rstn)
        (cycle_start && !oc_seen_ff) |=> (oc_cnt_ff == 2'h0);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");

    property p_cnt_inc;
        @(posedge core_clk) disable iff (!rstn)
        (cycle_start && oc_seen_ff && oc_cnt_ff < 2'h3) |=> (oc_cnt_ff == $past(oc_cnt_ff) + 2'h1);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("count not advanced");

    property p_oc_flag;
        @(posedge core_clk) disable iff (!rstn)
        oc_fault_evt |=> stat_iout_ff[7];
    endproperty
    a_oc_flag: assert property (p_oc_flag) else $error("oc flag missing");

    property p_latch_off;
        @(posedge core_clk) disable iff (!rstn)
        (oc_fault_evt && state_ff == OC_RUN && oc_resp_ff == 2'b00) |=> !convert_enable [*3];
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("latch not off");

    property p_ignore_runs;
        @(posedge core_clk) disable iff (!rstn)
        (state_ff == OC_RUN && oc_resp_ff == 2'b10) |=> state_ff == OC_RUN;
    endproperty
    a_ignore_runs: assert property (p_ignore_runs) else $error("ignore shut down");

    property p_tsd_stop;
        @(posedge core_clk) disable iff (!rstn)
        (die_temp_valid && die_temp > 16'sd145) |=> !convert_enable ##1 stat_mfr_ff[7];
    endproperty
    a_tsd_stop: assert property (p_tsd_stop) else $error("no thermal stop");

    property p_ss_fixed;
        @(posedge core_clk) disable iff (!rstn)
        !misc_opts_ff[0] |=> (ext_read_ff == 16'sd25);
    endproperty
    a_ss_fixed: assert property (p_ss_fixed) else $error("reading not fixed");

    property p_gnd_nofault;
        @(posedge core_clk) disable iff (!rstn)
        (sensor_pin_grounded && misc_opts_ff[0]) |-> !ext_fault_now ##1 (ext_read_ff == -16'sd40);
    endproperty
    a_gnd_nofault: assert property (p_gnd_nofault) else $error("grounded pin tripped");

    property p_alert;
        @(posedge core_clk) disable iff (!rstn)
        (stat_temp_ff[7] && !alert_mask_ff[1]) |-> !alert_n;
    endproperty
    a_alert: assert property (p_alert) else $error("alert missing");

    c_hiccup: cover property (@(posedge core_clk) disable iff (!rstn) softstart_req);
    c_recover: cover property (@(posedge core_clk) disable iff (!rstn)
        state_ff == OC_RESTART ##1 state_ff == OC_RUN);
    c_ext_halt: cover property (@(posedge core_clk) disable iff (!rstn) ext_halt_ff);
endmodule : fault_supervisor

/* File: fault_pkg.sv */
/*
 * Shared constants of the overcurrent / over-temperature supervisor:
 * command codes, field positions, reset values, response encodings.
 * Assumes a PMBus command decoder upstream that presents decoded codes.
 */
package fault_pkg;
    // Command codes of the registers
    localparam logic [7:0] CMD_CAL_OFFSET = 8'h39;
    localparam logic [7:0] CMD_OC_FAULT_THR = 8'h46;
    localparam logic [7:0] CMD_OC_RESPONSE = 8'h47;
    localparam logic [7:0] CMD_OC_WARN_THR = 8'h4A;
    localparam logic [7:0] CMD_OT_FAULT_THR = 8'h4F;
    localparam logic [7:0] CMD_OT_RESPONSE = 8'h50;
    localparam logic [7:0] CMD_OT_WARN_THR = 8'h51;
    localparam logic [7:0] CMD_STATUS_IOUT = 8'h7B;
    localparam logic [7:0] CMD_STATUS_TEMP = 8'h7D;
    localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
    localparam logic [7:0] CMD_IOUT_TELEM = 8'h8C;
    localparam logic [7:0] CMD_EXT_TEMP = 8'h8E;
    localparam logic [7:0] CMD_ALERT_MASK = 8'hD1;
    localparam logic [7:0] CMD_MISC_OPTS = 8'hE5;

    // Field positions
    localparam int STAT_OC_FAULT_BIT = 7;
    localparam int STAT_OC_WARN_BIT = 5;
    localparam int STAT_OT_FAULT_BIT = 7;
    localparam int STAT_OT_WARN_BIT = 6;
    localparam int MFR_INTERNAL_OVERTEMP_FLAG_BIT = 7;
    localparam int MISC_SSDD_BIT = 0;
    localparam int MASK_IOUT_BIT = 0;
    localparam int MASK_TEMP_BIT = 1;
    localparam int MASK_MFR_BIT = 2;

    // Reset values
    localparam logic [15:0] RST_CAL_OFFSET = 16'h0000;
    localparam logic [15:0] RST_OC_FAULT_THR = 16'h0100;
    localparam logic [15:0] RST_OC_WARN_THR = 16'h00C0;
    localparam logic [15:0] RST_OT_FAULT_THR = 16'h007D;
    localparam logic [15:0] RST_OT_WARN_THR = 16'h0064;
    localparam logic [15:0] RST_MISC_OPTS = 16'h0000;
    localparam logic [7:0] RST_ALERT_MASK = 8'h00;

    // Counts and temperatures (signed degrees C)
    localparam logic [1:0] OC_EVENTS_TO_FAULT = 2'h3;
    localparam logic [2:0] HICCUP_SS_PERIODS = 3'h7;
    localparam logic signed [15:0] TSD_DEG = 16'sd145;
    localparam logic signed [15:0] TSD_HYST_DEG = 16'sd20;
    localparam logic signed [15:0] EXT_RECOVER_DEG = 16'sd20;
    localparam logic signed [15:0] EXT_FLOOR_DEG = -16'sd40;
    localparam logic signed [15:0] EXT_SS_MODE_DEG = 16'sd25;

    // Response encodings
    typedef enum logic [1:0] {
        RESP_LATCH = 2'b00,
        RESP_RESTART = 2'b01,
        RESP_IGNORE = 2'b10
    } resp_t;
    localparam logic [1:0] RST_RESPONSE = 2'b01;
endpackage : fault_pkg

/* File: current_averager.sv */
/*
 * Exponential averager for calibrated output-current samples.
 * Assumes one sample strobe per switching cycle on the core clock.
 */
`timescale 1ns/1ns
module current_averager #(
    parameter int SHIFT = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Samples in
    input wire logic sample_valid,
    input wire logic signed [15:0] sample,
    // Average out
    output logic signed [15:0] average
);
    logic signed [15+SHIFT:0] acc_ff;
    logic signed [15+SHIFT:0] diff;

    // Fractional accumulator keeps precision that a plain shift would lose
    assign diff = (16 + SHIFT)'(sample) - (16 + SHIFT)'(acc_ff >>> SHIFT);
    assign average = 16'(acc_ff >>> SHIFT);

    // Each sample pulls the average one step toward it
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            acc_ff <= '0;
        end else if (sample_valid) begin
            acc_ff <= acc_ff + diff;
        end
    end
endmodule : current_averager

/* File: power_stage_model.sv */
/*
 * Power-stage sense model: free-running 8-clock switching cycles.
 * Assumes the bench injects faults through ls_oc and hs_oc.
 */
`timescale 1ns/1ns
module power_stage_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Fault injection
    input wire logic ls_oc,
    input wire logic hs_oc,
    // Sense outputs
    output logic cycle_start,
    output logic ls_mid,
    output logic [15:0] cur_sample,
    output logic hs_on,
    output logic peak_oc
);
    logic [2:0] phase_ff;
    // Phase counter, one switching cycle per wrap
    always_ff @(posedge core_clk) begin
        phase_ff <= rstn ? phase_ff + 3'h1 : 3'h0;
    end
    // Away from the midpoint the sample is junk, so a wrong strobe shows
    always_comb begin
        cycle_start = (phase_ff == 3'h0) & rstn;
        hs_on = (phase_ff >= 3'h1) && (phase_ff <= 3'h3);
        ls_mid = (phase_ff == 3'h5);
        cur_sample = ls_mid ? (ls_oc ? 16'h0200 : 16'h0040) : {13'h0, phase_ff} ^ 16'hA5A5;
        peak_oc = hs_oc & hs_on; // Comparator trips only with the gate on
    end
endmodule : power_stage_model

/* File: fault_supervisor_test.sv */
/*
 * Directed bench of the fault supervisor: register calls and sense stimulus.
 * Assumes power_stage_model drives the switching-cycle inputs.
 */
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
    $display("Error %s expected %h seen %h", n, e, a); fail_count++; end end
module fault_supervisor_test;
    logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_cmd = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rdata, cur_sample;
    logic reg_rvalid, cycle_start, ls_mid, hs_on, peak_oc, hs_terminate, convert_enable;
    logic softstart_req, softstart_detect_sel, alert_n, ls_oc = 1'b0, hs_oc = 1'b0;
    logic ss_period_tick = 1'b0, ss_done = 1'b0, die_temp_valid = 1'b0, ext_temp_valid = 1'b0;
    logic sensor_pin_grounded = 1'b0;
    logic signed [15:0] die_temp = 16'h0000, ext_temp = 16'h0000;
    int fail_count = 0, tests_run = 0, ss_seen = 0;
    always #25 core_clk = ~core_clk;
    // Count restart requests; the pulse is too short to poll from a task
    always @(posedge core_clk) if (softstart_req === 1'b1) ss_seen++;
    power_stage_model i_ps (.core_clk, .rstn, .ls_oc, .hs_oc, .cycle_start, .ls_mid,
        .cur_sample, .hs_on, .peak_oc);
    fault_supervisor i_dut (.core_clk, .rstn, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata,
        .reg_rdata, .reg_rvalid, .cycle_start, .ls_mid, .cur_sample, .hs_on,
        .high_side_peak_overcurrent(peak_oc), .ss_period_tick, .ss_done, .die_temp_valid,
        .die_temp, .ext_temp_valid, .ext_temp, .sensor_pin_grounded, .hs_terminate,
        .convert_enable, .softstart_req, .softstart_detect_sel, .alert_n);
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge core_clk);
        {reg_cmd, reg_wdata, reg_wr} = {c, d, 1'b1};
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr
    // Read with a bounded wait for the answer strobe
    task automatic rd(input string n, input logic [7:0] c, input logic [15:0] e);
        @(negedge core_clk);
        {reg_cmd, reg_rd} = {c, 1'b1};
        @(negedge core_clk);
        reg_rd = 1'b0;
        for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge core_clk);
        rdata = reg_rdata;
        `CHK(n, e, rdata)
    endtask : rd
    task automatic temp(input logic die, input logic [15:0] v);
        @(negedge core_clk);
        {die_temp, ext_temp, die_temp_valid, ext_temp_valid} = {v, v, die, !die};
        @(negedge core_clk);
        {die_temp_valid, ext_temp_valid} = 2'b00;
        repeat (2) @(negedge core_clk);
    endtask : temp
    task automatic cyc(input int n);
        repeat (n) @(posedge cycle_start);
        repeat (3) @(negedge core_clk);
    endtask : cyc
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge core_clk) ss_period_tick = 1'b1;
            @(negedge core_clk) ss_period_tick = 1'b0;
        end
        repeat (2) @(negedge core_clk);
    endtask : ticks
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    initial begin
        // Roughly seven times the directed run, so only a hang gets here
        #300000;
        fail_count++;
        summarize();
    end
    initial begin
        repeat (5) @(negedge core_clk);
        rstn = 1'b1;
        rd("ot_fault_thr", 8'h4F, fault_pkg::RST_OT_FAULT_THR);
        rd("ot_warn_thr", 8'h51, fault_pkg::RST_OT_WARN_THR);
        rd("unmapped", 8'h00, 16'h0000);
        `CHK("pin_sel", 1'b1, softstart_detect_sel)
        temp(1'b0, 16'h0050);
        wr(8'h8E, 16'h1234);
        rd("ext_ss_mode", 8'h8E, 16'h0019);
        // Two events, a clean cycle, two more: must not fault
        cyc(1);
        ls_oc = 1'b1;
        cyc(2);
        ls_oc = 1'b0;
        cyc(1);
        ls_oc = 1'b1;
        cyc(2);
        ls_oc = 1'b0;
        cyc(1);
        rd("oc_status", 8'h7B, 16'h0020);
        ls_oc = 1'b1;
        cyc(3);
        ls_oc = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK("oc_halt", 1'b0, convert_enable)
        `CHK("oc_alert", 1'b0, alert_n)
        rd("oc_fault", 8'h7B, 16'h00A0);
        ticks(6);
        `CHK("hiccup_wait", 0, ss_seen)
        ticks(1);
        `CHK("hiccup_restart", 1, ss_seen)
        `CHK("restart_run", 1'b1, convert_enable)
        @(negedge core_clk) ss_done = 1'b1;
        @(negedge core_clk) ss_done = 1'b0;
        cyc(4);
        `CHK("regulating", 1'b1, convert_enable)
        wr(8'hD1, 16'h0001);
        `CHK("alert_masked", 1'b1, alert_n)
        wr(8'h7B, 16'h00FF);
        wr(8'hD1, 16'h0000);
        // Ignore response: pulses still cut, no shutdown
        wr(8'h47, 16'h0002);
        hs_oc = 1'b1;
        cyc(1);
        `CHK("hs_cut", 1'b1, hs_terminate)
        cyc(4);
        hs_oc = 1'b0;
        `CHK("ignore_run", 1'b1, convert_enable)
        wr(8'h7B, 16'h00FF);
        wr(8'hE5, 16'h0001);
        `CHK("pin_sel", 1'b0, softstart_detect_sel)
        temp(1'b0, 16'h003C);
        rd("ext_read", 8'h8E, 16'h003C);
        temp(1'b0, 16'h0082);
        `CHK("ext_halt", 1'b0, convert_enable)
        `CHK("ot_alert", 1'b0, alert_n)
        rd("temp_status", 8'h7D, 16'h00C0);
        temp(1'b0, 16'h006A);
        `CHK("ext_still", 1'b0, convert_enable)
        temp(1'b0, 16'h0069);
        `CHK("ext_resume", 1'b1, convert_enable)
        wr(8'h7D, 16'h00FF);
        wr(8'h51, 16'h0032);
        temp(1'b0, 16'h003C);
        rd("warn_prog", 8'h7D, 16'h0040);
        sensor_pin_grounded = 1'b1;
        temp(1'b0, 16'h00C8);
        rd("ext_floor", 8'h8E, 16'hFFD8);
        `CHK("no_ext_fault", 1'b1, convert_enable)
        temp(1'b1, 16'h0092);
        `CHK("tsd_halt", 1'b0, convert_enable)
        rd("mfr_status", 8'h80, 16'h0080);
        temp(1'b1, 16'h007E);
        `CHK("tsd_hyst", 1'b0, convert_enable)
        temp(1'b1, 16'h007D);
        `CHK("tsd_resume", 1'b1, convert_enable)
        // Latch responses hold conversion off; only a reset brings it back
        sensor_pin_grounded = 1'b0;
        wr(8'h50, 16'h0000);
        temp(1'b0, 16'h0082);
        temp(1'b0, 16'h0032);
        `CHK("ot_latched", 1'b0, convert_enable)
        @(negedge core_clk) rstn = 1'b0;
        repeat (5) @(negedge core_clk);
        rstn = 1'b1;
        `CHK("reset_run", 1'b1, convert_enable)
        `CHK("reset_alert", 1'b1, alert_n)
        wr(8'h47, 16'h0000);
        cyc(1);
        ls_oc = 1'b1;
        cyc(3);
        ls_oc = 1'b0;
        cyc(2);
        `CHK("oc_latched", 1'b0, convert_enable)
        // Offset lifts the clean sample over the warn level but not the fault level
        wr(8'h7B, 16'h00FF);
        wr(8'h39, 16'h0090);
        cyc(60);
        rd("iout_telem", 8'h8C, 16'h00D0);
        rd("cal_warn", 8'h7B, 16'h0020);
        summarize();
    end
endmodule : fault_supervisor_test
